// >>> verilog/cci_defines.svh
// Register offsets, field positions, reset values and timing counts for the
// converter clock and input control block.
// Assumes inclusion by bare name from the design files.
`ifndef CCI_DEFINES_SVH
`define CCI_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
// The converter registers keep their word index; the bus is a word wide, so
// the byte address is four times the index.
`define CCI_INPUT_CTRL_IDX    10'h0a5
`define CCI_DATA_CONV_IDX     10'h0a4
`define CCI_INPUT_CTRL_ADDR   {`CCI_INPUT_CTRL_IDX, 2'b00}
`define CCI_DATA_CONV_ADDR    {`CCI_DATA_CONV_IDX, 2'b00}
`define CCI_IRQ_STATUS_ADDR   12'h0b0
`define CCI_IRQ_ENABLE_ADDR   12'h0b4
`define CCI_IRQ_CLEAR_ADDR    12'h0b8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CCI_IC_CONNECT        7
`define CCI_IC_INT_REF        6
`define CCI_IC_TRG_HI         5
`define CCI_IC_TRG_LO         4
`define CCI_IC_BALANCED       3
`define CCI_IC_CHAN_HI        2
`define CCI_DC_DONE           7
`define CCI_DC_BUSY           6
`define CCI_DC_ENABLE         4
`define CCI_DC_CLK_HI         2

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define CCI_INPUT_CTRL_RST    8'h00
`define CCI_DATA_CONV_RST     8'h00
`define CCI_CONV_TICKS        8'h0d

`endif

// >>> verilog/cci_pkg.sv
// Types shared by the converter clock and input control files.
// Assumes the defines header is also available.
package cci_pkg;
  typedef enum logic [2:0] {
    TRG_SOFTWARE = 3'b001,
    TRG_TIMER0   = 3'b010,
    TRG_TIMER1   = 3'b100
  } cci_trig_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } cci_state_type;
endpackage

// >>> verilog/cci_clock_divider.sv
// Converter clock divider: divides the raw oscillator by 2..128.
// Assumes core_clk is the undivided oscillator; the divider has no separate clock input.
`timescale 1ns/10ps
module cci_clock_divider #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  // Control
  input  wire logic [2:0] clkSel,
  // Output tick
  output logic            convTick
);
  // Any other width would truncate or pad the terminal count.
  if (DIV_W != 7)
  begin : gBadWidth
    $error("cci_clock_divider: DIV_W must be 7");
  end

  logic [DIV_W-1:0] count_r;
  logic [DIV_W-1:0] count_nxt;
  logic             tick_r;
  logic             tick_nxt;
  logic [DIV_W-1:0] lastCount;

  // Terminal count is ratio minus one; code 000 keeps the divider stopped.
  always_comb
  begin
    lastCount = DIV_W'((8'h01 << clkSel) - 8'h01);
    tick_nxt  = 1'b0;
    count_nxt = count_r + 7'h01;
    if (clkSel == 3'h0)
    begin
      count_nxt = 7'h00;
    end
    else if (count_r >= lastCount)
    begin
      count_nxt = 7'h00;
      tick_nxt  = 1'b1;
    end
  end

  // Registered so the tick comes straight from a flip-flop.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_r <= 7'h00;
      tick_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      count_r <= count_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign convTick = tick_r;
endmodule // cci_clock_divider

// >>> verilog/cci_converter_control.sv
// Converter clock and input control: APB registers, trigger logic, clock
// divider and analog control outputs.
// Assumes APB master on core_clk; timer overflow pulses from same clock.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "cci_defines.svh"
module cci_converter_control (
  // Clock, reset and clock enable
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core events
  input  wire logic        timer0Ovf,
  input  wire logic        timer1Ovf,
  input  wire logic        isrEntry,
  // Analog control, done flag and interrupt
  output logic             inputConnect,
  output logic             internalRefSelect,
  output logic             balancedInputMode,
  output logic [2:0]       channelSelect,
  output logic             convClkTick,
  output logic             convStart,
  output logic             conversionDoneFlag,
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  logic [7:0]  inCtrl_r, inCtrl_nxt;
  logic [7:0]  dataConv_r, dataConv_nxt;
  logic [1:0]  irqStat_r, irqStat_nxt;
  logic [1:0]  irqEn_r, irqEn_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [7:0]  convCnt_r, convCnt_nxt;
  logic        start_r, start_nxt;
  logic        irq_r, irq_nxt;
  logic        ic_r [2];
  cci_pkg::cci_state_type state_r, state_nxt;
  cci_pkg::cci_trig_type  trig;
  logic        divTick;
  logic        wrAcc, rdAcc, trigger, finish;

  // Decode used for both read and write paths.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `CCI_INPUT_CTRL_ADDR) || (a == `CCI_DATA_CONV_ADDR) ||
             (a == `CCI_IRQ_STATUS_ADDR) || (a == `CCI_IRQ_ENABLE_ADDR) ||
             (a == `CCI_IRQ_CLEAR_ADDR);
  endfunction

  function automatic cci_pkg::cci_trig_type decodeTrig(input logic [1:0] f);
    case (f)
      2'b01:   decodeTrig = cci_pkg::TRG_TIMER0;
      2'b10:   decodeTrig = cci_pkg::TRG_TIMER1;
      default: decodeTrig = cci_pkg::TRG_SOFTWARE;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Converter clock
  // --------------------------------------------------------------------------
  cci_clock_divider #(
    .DIV_W (7)
  ) uDiv (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .clkSel   (dataConv_r[`CCI_DC_CLK_HI:0]),
    .convTick (divTick)
  );

  // --------------------------------------------------------------------------
  // Bus and conversion logic
  // --------------------------------------------------------------------------
  // Access completes one cycle after setup; pready is registered.
  assign wrAcc = psel && penable && pready_r && pwrite;
  assign rdAcc = psel && !penable && !pwrite;

  // Reserved trigger code 11 is treated as software so starts never hang.
  always_comb
  begin
    trig = decodeTrig(inCtrl_r[`CCI_IC_TRG_HI:`CCI_IC_TRG_LO]);
    trigger = 1'b0;
    if (dataConv_r[`CCI_DC_ENABLE] && state_r == cci_pkg::ST_IDLE)
    begin
      case (trig)
        cci_pkg::TRG_TIMER0: trigger = timer0Ovf;
        cci_pkg::TRG_TIMER1: trigger = timer1Ovf;
        default:             trigger = wrAcc && paddr == `CCI_DATA_CONV_ADDR
                                       && pwdata[`CCI_DC_BUSY];
      endcase
    end
    finish = state_r == cci_pkg::ST_CONV && convCnt_r == 8'h00 && divTick;
  end

  // Register, flag and sequencer next-state logic.
  always_comb
  begin
    inCtrl_nxt   = inCtrl_r;
    dataConv_nxt = dataConv_r;
    irqStat_nxt  = irqStat_r;
    irqEn_nxt    = irqEn_r;
    state_nxt    = state_r;
    convCnt_nxt  = convCnt_r;
    pready_nxt   = psel && !penable;
    pslverr_nxt  = psel && !penable && !mapped(paddr);
    prdata_nxt   = 32'h0;
    start_nxt    = trigger;
    if (rdAcc)
    begin
      case (paddr)
        `CCI_INPUT_CTRL_ADDR: prdata_nxt = {24'h0, inCtrl_r};
        `CCI_DATA_CONV_ADDR:  prdata_nxt = {24'h0, dataConv_r};
        `CCI_IRQ_STATUS_ADDR: prdata_nxt = {30'h0, irqStat_r};
        `CCI_IRQ_ENABLE_ADDR: prdata_nxt = {30'h0, irqEn_r};
        default:              prdata_nxt = 32'h0;
      endcase
    end
    if (wrAcc)
    begin
      case (paddr)
        `CCI_INPUT_CTRL_ADDR: inCtrl_nxt = pwdata[7:0];
        `CCI_DATA_CONV_ADDR:  dataConv_nxt = {dataConv_r[7:6], pwdata[5:0]};
        `CCI_IRQ_ENABLE_ADDR: irqEn_nxt = pwdata[1:0];
        `CCI_IRQ_CLEAR_ADDR:  irqStat_nxt = irqStat_r & ~pwdata[1:0];
        default:              irqEn_nxt = irqEn_r;
      endcase
    end
    if (isrEntry)
    begin
      dataConv_nxt[`CCI_DC_DONE] = 1'b0;
    end
    case (state_r)
      cci_pkg::ST_IDLE:
      begin
        if (trigger)
        begin
          state_nxt   = cci_pkg::ST_CONV;
          convCnt_nxt = `CCI_CONV_TICKS;
          dataConv_nxt[`CCI_DC_BUSY] = 1'b1;
          irqStat_nxt[1] = 1'b1;
        end
      end
      cci_pkg::ST_CONV:
      begin
        if (divTick && convCnt_r != 8'h00)
        begin
          convCnt_nxt = convCnt_r - 8'h01;
        end
        if (finish)
        begin
          state_nxt = cci_pkg::ST_IDLE;
          dataConv_nxt[`CCI_DC_BUSY] = 1'b0;
          dataConv_nxt[`CCI_DC_DONE] = 1'b1;
          irqStat_nxt[0] = 1'b1;
        end
      end
      default: state_nxt = cci_pkg::ST_IDLE;
    endcase
    irq_nxt = |(irqStat_nxt & irqEn_nxt);
  end

  // Registered state; reset to zero everywhere except state_r, which loads ST_IDLE.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      inCtrl_r   <= `CCI_INPUT_CTRL_RST;
      dataConv_r <= `CCI_DATA_CONV_RST;
      irqStat_r  <= 2'h0;
      irqEn_r    <= 2'h0;
      prdata_r   <= 32'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      convCnt_r  <= 8'h00;
      start_r    <= 1'b0;
      irq_r      <= 1'b0;
      state_r    <= cci_pkg::ST_IDLE;
    end
    else if (clkEn)
    begin
      inCtrl_r   <= inCtrl_nxt;
      dataConv_r <= dataConv_nxt;
      irqStat_r  <= irqStat_nxt;
      irqEn_r    <= irqEn_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      convCnt_r  <= convCnt_nxt;
      start_r    <= start_nxt;
      irq_r      <= irq_nxt;
      state_r    <= state_nxt;
    end
  end

  // Analog outputs mirror the control register fields, one flop each except balancedInputMode, taken from inCtrl_r.
  generate
    for (genvar i = 0; i < 2; i++)
    begin : gIc
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
          ic_r[i] <= 1'b0;
        else if (clkEn)
          ic_r[i] <= inCtrl_nxt[i+`CCI_IC_INT_REF];
      end
    end
  endgenerate

  logic [2:0] chan_r;
  logic       tickOut_r;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chan_r    <= 3'h0;
      tickOut_r <= 1'b0;
    end
    else if (clkEn)
    begin
      chan_r    <= inCtrl_nxt[`CCI_IC_CHAN_HI:0];
      tickOut_r <= divTick;
    end
  end

  // Software is expected to clear connect before changing channel.
  assign inputConnect       = ic_r[1];
  assign internalRefSelect  = ic_r[0];
  assign balancedInputMode  = inCtrl_r[`CCI_IC_BALANCED];
  assign channelSelect      = chan_r;
  assign convClkTick        = tickOut_r;
  assign convStart          = start_r;
  assign conversionDoneFlag = dataConv_r[`CCI_DC_DONE];
  assign irq                = irq_r;
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
endmodule // cci_converter_control

// >>> test/cci_converter_control_props.sv
// Port checker for the converter control block.
// Assumes a bind onto cci_converter_control and one clock domain.
`timescale 1ns/10ps
`include "cci_defines.svh"
module cci_converter_control_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        clkEn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events and outputs
  input wire logic        isrEntry,
  input wire logic        inputConnect,
  input wire logic        internalRefSelect,
  input wire logic        balancedInputMode,
  input wire logic [2:0]  channelSelect,
  input wire logic        convClkTick,
  input wire logic        conversionDoneFlag
);
  logic       wrIc;
  logic [7:0] shadow_r;
  // A shadow of the last accepted input control write, so outputs are judged by cause.
  assign wrIc = psel && penable && pready && pwrite && clkEn && paddr == `CCI_INPUT_CTRL_ADDR;
  // Updated only on the edge that takes the write.
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) shadow_r <= 8'h00;
    else if (wrIc) shadow_r <= pwdata[7:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_ready; psel && !penable && clkEn |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  property p_pulse; pready && clkEn |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_unmap; psel && !penable && clkEn && paddr == 12'h0c0 |=> pslverr && pready; endproperty
  a_unmap: assert property (p_unmap) else $error("no slave error");
  property p_conn; !wrIc && !$past(wrIc) |-> inputConnect == shadow_r[7]; endproperty
  a_conn: assert property (p_conn) else $error("connect wrong");
  property p_chan; !wrIc && !$past(wrIc) |-> channelSelect == shadow_r[2:0]; endproperty
  a_chan: assert property (p_chan) else $error("channel wrong");
  property p_ref; !wrIc && !$past(wrIc) |-> internalRefSelect == shadow_r[6]; endproperty
  a_ref: assert property (p_ref) else $error("reference wrong");
  property p_mode; !wrIc && !$past(wrIc) |-> balancedInputMode == shadow_r[3]; endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_tick; convClkTick && clkEn |=> !convClkTick; endproperty
  a_tick: assert property (p_tick) else $error("tick too fast");
  property p_isr; isrEntry && clkEn |=> ##[0:1] !conversionDoneFlag; endproperty
  a_isr: assert property (p_isr) else $error("done not cleared");
endmodule // cci_converter_control_props

bind cci_converter_control cci_converter_control_props chk_u (
  .core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .isrEntry(isrEntry), .inputConnect(inputConnect), .internalRefSelect(internalRefSelect),
  .balancedInputMode(balancedInputMode), .channelSelect(channelSelect),
  .convClkTick(convClkTick), .conversionDoneFlag(conversionDoneFlag));

// >>> test/converter_clock_and_input_control_tb.sv
// Self-checking bench for the converter control block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`include "cci_defines.svh"
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, x); end end
module converter_clock_and_input_control_tb;
  logic        core_clk = 0, rstn = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        timer0Ovf = 0, timer1Ovf = 0, isrEntry = 0, pready, pslverr, e, s;
  logic        inputConnect, internalRefSelect, balancedInputMode, convClkTick;
  logic        convStart, conversionDoneFlag, irq;
  logic [2:0]  channelSelect;
  int          num_errors = 0, num_checks = 0;
  // Free-running 40 MHz clock.
  always #12.5 core_clk = ~core_clk;
  cci_converter_control dut_u (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer0Ovf(timer0Ovf),
    .timer1Ovf(timer1Ovf), .isrEntry(isrEntry), .inputConnect(inputConnect),
    .internalRefSelect(internalRefSelect), .balancedInputMode(balancedInputMode),
    .channelSelect(channelSelect), .convClkTick(convClkTick), .convStart(convStart),
    .conversionDoneFlag(conversionDoneFlag), .irq(irq));
  // One transfer; ready and the answer are taken at the same rising edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Pulses the timers and reports whether a conversion was launched.
  task automatic kick(input logic t0, input logic t1, input logic x);
    @(posedge core_clk);
    timer0Ovf <= t0;
    timer1Ovf <= t1;
    @(posedge core_clk);
    timer0Ovf <= 0;
    timer1Ovf <= 0;
    s = 0;
    repeat (6) @(negedge core_clk) if (convStart === 1'b1) s = 1;
    `CHK(s, x)
  endtask
  // Bounded wait for completion, then the service entry clears it.
  task automatic finish_conv;
    int n;
    n = 0;
    while (conversionDoneFlag !== 1'b1 && n < 4000) @(negedge core_clk) n++;
    `CHK(conversionDoneFlag, 1'b1)
    @(posedge core_clk);
    isrEntry <= 1;
    @(posedge core_clk);
    isrEntry <= 0;
    repeat (2) @(negedge core_clk);
    `CHK(conversionDoneFlag, 1'b0)
  endtask
  task automatic t_regs;
    bus(0, `CCI_INPUT_CTRL_ADDR, 0);
    `CHK(q[7:0], 8'h00)
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'h4d);
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'hcd);
    bus(0, `CCI_INPUT_CTRL_ADDR, 0);
    `CHK(q, 32'hcd)
    `CHK({inputConnect, internalRefSelect, balancedInputMode}, 3'h7)
    `CHK(channelSelect, 3'h5)
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'h4d);
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'h02);
    bus(0, 12'h0c0, 0);
    `CHK({inputConnect, internalRefSelect, balancedInputMode}, 3'h0)
    `CHK(channelSelect, 3'h2)
    `CHK(e, 1'b1)
    $display("test regs done");
  endtask
  task automatic t_div;
    int n;
    for (int c = 1; c < 8; c++)
    begin
      bus(1, `CCI_DATA_CONV_ADDR, c);
      repeat (2)
      begin
        n = 0;
        @(negedge core_clk);
        while (convClkTick !== 1'b1 && n < 300) @(negedge core_clk) n++;
      end
      `CHK(n + 1, 1 << c)
    end
    $display("test divider done");
  endtask
  // With the enable low the divider must hold its tick output still.
  task automatic t_freeze;
    bus(1, `CCI_DATA_CONV_ADDR, 32'h01);
    @(posedge core_clk);
    clkEn <= 0;
    @(negedge core_clk);
    s = convClkTick;
    e = 0;
    repeat (6) @(negedge core_clk) if (convClkTick !== s) e = 1;
    `CHK(e, 1'b0)
    @(posedge core_clk);
    clkEn <= 1;
    $display("test freeze done");
  endtask
  task automatic t_soft;
    bus(1, `CCI_DATA_CONV_ADDR, 32'h11);
    kick(1, 1, 0);
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'h32);
    kick(1, 1, 0);
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'h02);
    bus(1, `CCI_DATA_CONV_ADDR, 32'h51);
    bus(0, `CCI_DATA_CONV_ADDR, 0);
    `CHK(q[6], 1'b1)
    repeat (80) @(negedge core_clk);
    bus(0, `CCI_DATA_CONV_ADDR, 0);
    `CHK(q[7:6], 2'b10)
    `CHK(irq, 1'b0)
    bus(0, `CCI_IRQ_STATUS_ADDR, 0);
    `CHK(q[0], 1'b1)
    bus(1, `CCI_IRQ_ENABLE_ADDR, 1);
    repeat (2) @(negedge core_clk);
    `CHK(irq, 1'b1)
    bus(1, `CCI_IRQ_CLEAR_ADDR, 1);
    repeat (2) @(negedge core_clk);
    `CHK(irq, 1'b0)
    finish_conv;
    $display("test software start done");
  endtask
  task automatic t_timer;
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'h10);
    kick(0, 1, 0);
    kick(1, 0, 1);
    finish_conv;
    bus(1, `CCI_INPUT_CTRL_ADDR, 32'h20);
    kick(1, 0, 0);
    kick(0, 1, 1);
    finish_conv;
    $display("test timer trigger done");
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence after a 20-cycle reset.
  initial
  begin
    repeat (20) @(posedge core_clk);
    rstn <= 1;
    t_regs;
    t_div;
    t_freeze;
    t_soft;
    t_timer;
    print_verdict;
  end
  // Watchdog well beyond the expected run of under a thousand cycles.
  initial
  begin
    #1000000;
    num_errors++;
    print_verdict;
  end
endmodule // converter_clock_and_input_control_tb
